// *** rtl/irq_lp_ctrl.sv ***
/*
 Interrupt enable, request sampling and idle / power-down control,
 with an AXI4-Lite register slave.
 Assumes timer pulses and the serial request come from logic on i_core_clk;
 pins and the reset pin are asynchronous and are synchronised here.
*/
`timescale 1ns/100ps
module irq_lp_ctrl (
    input  wire logic                  i_core_clk,
    input  wire logic                  i_rst_n,
    input  wire irq_lp_pkg::axil_req_t i_axil,
    output irq_lp_pkg::axil_rsp_t      o_axil,
    input  wire logic                  i_external_request_0_n,
    input  wire logic                  i_external_request_1_n,
    input  wire logic                  i_timer0_overflow,
    input  wire logic                  i_timer1_overflow,
    input  wire logic                  i_timer2_rollover,
    input  wire logic                  i_timer2_trigger_pin,
    input  wire logic                  i_serial_irq,
    input  wire logic                  i_reset_pin,
    input  wire logic                  i_vector_ack,
    input  wire logic [2:0]            i_vector_id,
    input  wire logic                  i_ext_program_mem,
    input  wire logic                  i_core_ale,
    input  wire logic                  i_core_program_store_strobe,
    output logic                       o_irq_request,
    output logic      [2:0]            o_irq_vector_id,
    output logic                       o_cpu_halt,
    output logic                       o_osc_stop,
    output logic                       o_internal_reset,
    output logic                       o_ram_write_block,
    output logic                       o_ale,
    output logic                       o_program_store_strobe,
    output logic                       o_port0_float,
    output logic                       o_port2_addr_drive
);
    irq_lp_pkg::state_t q;
    irq_lp_pkg::state_t d;

    logic [1:0] rst_sync_q;
    logic       rst_n;
    logic [3:0] pins_s;
    logic       reset_pin_s;
    logic       at_state5_phase2;
    logic       at_state2_phase2;
    logic       cycle_end;
    logic       trig_fall;
    logic       wr_fire;
    logic       pwr_wr;
    logic [5:0] raw_src;
    logic [5:0] pend_req;

    // Gating by the global bit is folded in here so wake-up and requests agree
    function automatic logic [5:0] enabled_src(input logic [7:0] ie);
        enabled_src = ie[5:0] & {6{ie[irq_lp_pkg::BIT_GLOBAL_IRQ_ENABLE]}};
    endfunction

    // Lowest index wins; order follows the vector table
    function automatic logic [2:0] first_set(input logic [5:0] v);
        first_set = 3'h0;
        for (int i = irq_lp_pkg::NUM_SOURCES - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 3'(i);
            end
        end
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == irq_lp_pkg::OFS_IRQ_ENABLE) || (a == irq_lp_pkg::OFS_TIMER2_CTRL)
                 || (a == irq_lp_pkg::OFS_POWER_CTRL) || (a == irq_lp_pkg::OFS_STATUS);
    endfunction

    function automatic logic [7:0] read_reg(input irq_lp_pkg::state_t s, input logic [7:0] a);
        read_reg = 8'h00;
        case (a)
            irq_lp_pkg::OFS_IRQ_ENABLE: begin
                read_reg = s.ie & irq_lp_pkg::IRQ_ENABLE_MASK;
            end
            irq_lp_pkg::OFS_TIMER2_CTRL: begin
                read_reg[irq_lp_pkg::BIT_T2_OVERFLOW_FLAG] = s.tf2;
                read_reg[irq_lp_pkg::BIT_T2_EXTERNAL_FLAG] = s.timer2_external_flag;
                read_reg[irq_lp_pkg::BIT_T2_EXTERNAL_EN]   = s.exen;
            end
            irq_lp_pkg::OFS_POWER_CTRL: begin
                read_reg[irq_lp_pkg::BIT_PWR_IDLE]  = (s.mode == irq_lp_pkg::MODE_IDLE);
                read_reg[irq_lp_pkg::BIT_PWR_PDOWN] = (s.mode == irq_lp_pkg::MODE_PDOWN);
            end
            irq_lp_pkg::OFS_STATUS: begin
                read_reg = {s.irq_req, 1'b0, s.poll};
            end
            default: begin
                read_reg = 8'h00;
            end
        endcase
    endfunction

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    sync_2ff #(
        .W (4)
    ) u_pin_sync (
        .i_clk   (i_core_clk),
        .i_rst_n (rst_n),
        .i_async ({i_reset_pin, i_timer2_trigger_pin,
                   i_external_request_1_n, i_external_request_0_n}),
        .o_sync  (pins_s)
    );
    assign reset_pin_s = pins_s[3];

    // Tick counter is the divide-by-two state clock: bit 0 is the phase
    assign at_state5_phase2   = (q.tick == irq_lp_pkg::TICK_STATE5_PHASE2);
    assign at_state2_phase2   = (q.tick == irq_lp_pkg::TICK_STATE2_PHASE2);
    assign cycle_end = (q.tick == irq_lp_pkg::TICK_LAST);
    assign trig_fall = q.trig_prev & ~pins_s[2];

    // External requests are level sensitive, active low
    assign raw_src = {q.tf2 | q.timer2_external_flag, i_serial_irq, q.tf1, ~pins_s[1], q.tf0, ~pins_s[0]};
    assign pend_req = q.poll & enabled_src(q.ie);

    assign wr_fire = q.aw_held & q.w_held & ~q.bvalid;
    assign pwr_wr  = wr_fire & q.w_strb0 & (q.aw_addr == irq_lp_pkg::OFS_POWER_CTRL);

    always_comb begin
        d = q;

        // Oscillator is frozen in power-down, so no state time advances
        if (q.mode != irq_lp_pkg::MODE_PDOWN) begin
            d.tick = cycle_end ? 4'h0 : q.tick + 4'h1;
        end

        // Vectoring clears only timer 0/1 flags; timer 2 flags stay for software
        if (i_vector_ack && i_vector_id == irq_lp_pkg::VEC_TIMER0) begin
            d.tf0 = 1'b0;
        end
        if (i_vector_ack && i_vector_id == irq_lp_pkg::VEC_TIMER1) begin
            d.tf1 = 1'b0;
        end

        // Register slave: address and data are taken independently
        if (i_axil.awvalid && !q.aw_held) begin
            d.aw_held = 1'b1;
            d.aw_addr = i_axil.awaddr;
        end
        if (i_axil.wvalid && !q.w_held) begin
            d.w_held  = 1'b1;
            d.w_data  = i_axil.wdata[7:0];
            d.w_strb0 = i_axil.wstrb[0];
        end
        if (q.bvalid && i_axil.bready) begin
            d.bvalid = 1'b0;
        end
        if (wr_fire) begin
            d.aw_held = 1'b0;
            d.w_held  = 1'b0;
            d.bvalid  = 1'b1;
            d.bresp   = is_mapped(q.aw_addr) ? irq_lp_pkg::RESP_OKAY : irq_lp_pkg::RESP_SLVERR;
            if (q.w_strb0 && q.aw_addr == irq_lp_pkg::OFS_IRQ_ENABLE) begin
                // Reserved bit is dropped so it always reads zero
                d.ie = q.w_data & irq_lp_pkg::IRQ_ENABLE_MASK;
            end
            if (q.w_strb0 && q.aw_addr == irq_lp_pkg::OFS_TIMER2_CTRL) begin
                d.tf2  = q.w_data[irq_lp_pkg::BIT_T2_OVERFLOW_FLAG];
                d.timer2_external_flag = q.w_data[irq_lp_pkg::BIT_T2_EXTERNAL_FLAG];
                d.exen = q.w_data[irq_lp_pkg::BIT_T2_EXTERNAL_EN];
            end
        end
        if (q.rvalid && i_axil.rready) begin
            d.rvalid = 1'b0;
        end
        if (i_axil.arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rdata  = read_reg(q, i_axil.araddr);
            d.rresp  = is_mapped(i_axil.araddr) ? irq_lp_pkg::RESP_OKAY : irq_lp_pkg::RESP_SLVERR;
        end

        // Hardware sets come after software clears, so a coincident event wins
        d.pend_t0 = q.pend_t0 | i_timer0_overflow;
        d.pend_t1 = q.pend_t1 | i_timer1_overflow;
        d.pend_t2 = q.pend_t2 | i_timer2_rollover;
        if (at_state5_phase2) begin
            d.tf0     = d.tf0 | d.pend_t0;
            d.tf1     = d.tf1 | d.pend_t1;
            d.pend_t0 = 1'b0;
            d.pend_t1 = 1'b0;
        end
        if (at_state2_phase2) begin
            d.tf2     = d.tf2 | d.pend_t2;
            d.pend_t2 = 1'b0;
        end
        if (trig_fall && q.exen) begin
            d.timer2_external_flag = 1'b1;
        end
        d.trig_prev = pins_s[2];

        // Poll sees the old flags: timer 0/1 set here show next cycle,
        // timer 2 set at state 2 shows in this one
        if (at_state5_phase2) begin
            d.poll = raw_src;
        end

        d.irq_req = (|pend_req) && (q.mode == irq_lp_pkg::MODE_RUN);
        d.irq_vec = first_set(pend_req);

        case (q.mode)
            irq_lp_pkg::MODE_RUN: begin
                if (reset_pin_s) begin
                    d.int_reset = 1'b1;
                end else if (pwr_wr && q.w_data[irq_lp_pkg::BIT_PWR_PDOWN]) begin
                    d.mode = irq_lp_pkg::MODE_PDOWN;
                end else if (pwr_wr && q.w_data[irq_lp_pkg::BIT_PWR_IDLE]) begin
                    d.mode = irq_lp_pkg::MODE_IDLE;
                end
            end
            irq_lp_pkg::MODE_IDLE: begin
                if (reset_pin_s) begin
                    d.mode    = irq_lp_pkg::MODE_RESET_WAIT;
                    d.rst_cnt = 2'h0;
                end else if (|pend_req) begin
                    d.mode = irq_lp_pkg::MODE_RUN;
                end
            end
            irq_lp_pkg::MODE_RESET_WAIT: begin
                // CPU runs on for two machine cycles before the reset lands
                if (cycle_end) begin
                    if (q.rst_cnt == irq_lp_pkg::IDLE_RESET_CYCLES - 2'h1) begin
                        d.int_reset = 1'b1;
                    end else begin
                        d.rst_cnt = q.rst_cnt + 2'h1;
                    end
                end
            end
            irq_lp_pkg::MODE_PDOWN: begin
                // Only the reset pin leaves power-down; settling is the board's job
                if (reset_pin_s) begin
                    d.int_reset = 1'b1;
                end
            end
            default: begin
                d.mode = irq_lp_pkg::MODE_RUN;
            end
        endcase

        // Internal reset reinitialises registers; RAM is outside and untouched
        if (q.int_reset) begin
            d.int_reset = reset_pin_s;
            d.mode      = irq_lp_pkg::MODE_RUN;
            d.rst_cnt   = 2'h0;
            d.ie        = irq_lp_pkg::IRQ_ENABLE_RESET;
            d.tf0       = 1'b0;
            d.tf1       = 1'b0;
            d.tf2       = 1'b0;
            d.timer2_external_flag      = 1'b0;
            d.exen      = 1'b0;
            d.pend_t0   = 1'b0;
            d.pend_t1   = 1'b0;
            d.pend_t2   = 1'b0;
            d.poll      = 6'h00;
            d.irq_req   = 1'b0;
        end

        // Strobes and port modes follow the next mode
        case (d.mode)
            irq_lp_pkg::MODE_IDLE: begin
                d.ale = 1'b1;
                d.pss = 1'b1;
            end
            irq_lp_pkg::MODE_PDOWN: begin
                d.ale = 1'b0;
                d.pss = 1'b0;
            end
            default: begin
                d.ale = i_core_ale;
                d.pss = i_core_program_store_strobe;
            end
        endcase
        d.p0_float = i_ext_program_mem && (d.mode == irq_lp_pkg::MODE_IDLE
                                        || d.mode == irq_lp_pkg::MODE_PDOWN);
        d.p2_addr  = i_ext_program_mem && (d.mode == irq_lp_pkg::MODE_IDLE);
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            q <= irq_lp_pkg::STATE_RESET;
        end else begin
            q <= d;
        end
    end

    always_comb begin
        o_axil         = '0;
        o_axil.awready = ~q.aw_held;
        o_axil.wready  = ~q.w_held;
        o_axil.bvalid  = q.bvalid;
        o_axil.bresp   = q.bresp;
        o_axil.arready = ~q.rvalid;
        o_axil.rvalid  = q.rvalid;
        o_axil.rdata   = {24'h0, q.rdata};
        o_axil.rresp   = q.rresp;
    end

    assign o_irq_request = q.irq_req;
    assign o_irq_vector_id = q.irq_vec;
    // Halt covers idle and power-down; the reset wait lets the CPU run
    assign o_cpu_halt = (q.mode == irq_lp_pkg::MODE_IDLE)
                     || (q.mode == irq_lp_pkg::MODE_PDOWN);
    assign o_osc_stop = (q.mode == irq_lp_pkg::MODE_PDOWN);
    assign o_internal_reset = q.int_reset;
    // Port writes are deliberately not blocked during the reset wait
    assign o_ram_write_block = (q.mode == irq_lp_pkg::MODE_RESET_WAIT);
    assign o_ale = q.ale;
    assign o_program_store_strobe = q.pss;
    assign o_port0_float = q.p0_float;
    assign o_port2_addr_drive = q.p2_addr;
endmodule

// *** rtl/irq_lp_pkg.sv ***
/*
 Constants, carrier structs and state of the interrupt and low-power block.
 Assumes one 200 MHz core clock; a machine cycle is 12 core clocks.
*/
package irq_lp_pkg;

    localparam int AXI_ADDR_W = 8;

    localparam logic [7:0] OFS_IRQ_ENABLE  = 8'h00;
    localparam logic [7:0] OFS_TIMER2_CTRL = 8'h04;
    localparam logic [7:0] OFS_POWER_CTRL  = 8'h08;
    localparam logic [7:0] OFS_STATUS      = 8'h0C;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int BIT_GLOBAL_IRQ_ENABLE = 7;
    localparam int BIT_TIMER2_IRQ_ENABLE = 5;
    localparam int BIT_SERIAL_IRQ_ENABLE = 4;
    localparam int BIT_TIMER1_IRQ_ENABLE = 3;
    localparam int BIT_EXT1_IRQ_ENABLE   = 2;
    localparam int BIT_TIMER0_IRQ_ENABLE = 1;
    localparam int BIT_EXT0_IRQ_ENABLE   = 0;
    localparam logic [7:0] IRQ_ENABLE_RESET = 8'h00;
    localparam logic [7:0] IRQ_ENABLE_MASK  = 8'hBF;

    localparam int BIT_T2_OVERFLOW_FLAG = 7;
    localparam int BIT_T2_EXTERNAL_FLAG = 6;
    localparam int BIT_T2_EXTERNAL_EN   = 3;

    localparam int BIT_PWR_IDLE  = 0;
    localparam int BIT_PWR_PDOWN = 1;

    localparam int NUM_SOURCES = 6;
    // Vector index equals the enable bit position of the source
    localparam logic [2:0] VEC_EXT0   = 3'h0;
    localparam logic [2:0] VEC_TIMER0 = 3'h1;
    localparam logic [2:0] VEC_EXT1   = 3'h2;
    localparam logic [2:0] VEC_TIMER1 = 3'h3;
    localparam logic [2:0] VEC_SERIAL = 3'h4;
    localparam logic [2:0] VEC_TIMER2 = 3'h5;

    // Tick = (state - 1) * 2 + (phase - 1), twelve ticks per machine cycle
    localparam logic [3:0] TICK_STATE2_PHASE2 = 4'h3;
    localparam logic [3:0] TICK_STATE5_PHASE2 = 4'h9;
    localparam logic [3:0] TICK_LAST          = 4'hB;
    localparam logic [1:0] IDLE_RESET_CYCLES  = 2'h2;

    typedef enum logic [1:0] {
        MODE_RUN        = 2'b00,
        MODE_IDLE       = 2'b01,
        MODE_PDOWN      = 2'b10,
        MODE_RESET_WAIT = 2'b11
    } mode_t;

    typedef struct packed {
        logic                  awvalid;
        logic [AXI_ADDR_W-1:0] awaddr;
        logic                  wvalid;
        logic [31:0]           wdata;
        logic [3:0]            wstrb;
        logic                  bready;
        logic                  arvalid;
        logic [AXI_ADDR_W-1:0] araddr;
        logic                  rready;
    } axil_req_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } axil_rsp_t;

    typedef struct packed {
        logic [3:0]            tick;
        mode_t                 mode;
        logic [1:0]            rst_cnt;
        logic                  int_reset;
        logic [7:0]            ie;
        logic                  tf0;
        logic                  tf1;
        logic                  tf2;
        logic                  timer2_external_flag;
        logic                  exen;
        logic                  pend_t0;
        logic                  pend_t1;
        logic                  pend_t2;
        logic                  trig_prev;
        logic [5:0]            poll;
        logic                  irq_req;
        logic [2:0]            irq_vec;
        logic                  ale;
        logic                  pss;
        logic                  p0_float;
        logic                  p2_addr;
        logic                  aw_held;
        logic [AXI_ADDR_W-1:0] aw_addr;
        logic                  w_held;
        logic [7:0]            w_data;
        logic                  w_strb0;
        logic                  bvalid;
        logic [1:0]            bresp;
        logic                  rvalid;
        logic [7:0]            rdata;
        logic [1:0]            rresp;
    } state_t;

    localparam state_t STATE_RESET = '0;

endpackage

// *** rtl/sync_2ff.sv ***
/*
 Two flip-flop synchroniser for a group of asynchronous levels.
 Assumes the reset given is already released in the destination clock domain.
*/
`timescale 1ns/100ps
module sync_2ff #(
    parameter int W = 1
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [2*W-1:0] chain_q;
    logic [2*W-1:0] chain_d;

    // Only the second stage is visible outside
    always_comb begin
        chain_d = {chain_q[W-1:0], i_async};
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            chain_q <= '0;
        end else begin
            chain_q <= chain_d;
        end
    end

    assign o_sync = chain_q[2*W-1:W];
endmodule

// *** test/irq_lp_checker.sv ***
/*
 Port assertions for the interrupt and low-power controller.
 Assumes it is bound into irq_lp_ctrl.
*/
`timescale 1ns/100ps
module irq_lp_checker (
    input wire logic                  i_core_clk,
    input wire logic                  i_rst_n,
    input wire irq_lp_pkg::axil_req_t i_axil,
    input wire irq_lp_pkg::axil_rsp_t o_axil,
    input wire logic                  o_irq_request,
    input wire logic                  o_cpu_halt,
    input wire logic                  o_osc_stop,
    input wire logic                  o_internal_reset,
    input wire logic                  o_ram_write_block,
    input wire logic                  o_ale,
    input wire logic                  o_program_store_strobe
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    sequence s_wr_both;
        i_axil.awvalid && o_axil.awready && i_axil.wvalid && o_axil.wready && !o_axil.bvalid;
    endsequence
    sequence s_pd2;
        o_osc_stop ##1 o_osc_stop;
    endsequence
    // Two cycles deep so the registered strobes have settled
    sequence s_idle2;
        (o_cpu_halt && !o_osc_stop) [*2];
    endsequence
    AST_WR_LAT: assert property (s_wr_both |-> ##2 o_axil.bvalid)
        else $error("late write answer");
    AST_RD_LAT: assert property (i_axil.arvalid && o_axil.arready |=> o_axil.rvalid)
        else $error("late read answer");
    AST_B_HOLD: assert property (o_axil.bvalid && !i_axil.bready
        |=> o_axil.bvalid && $stable(o_axil.bresp)) else $error("write answer dropped");
    AST_R_HOLD: assert property (o_axil.rvalid && !i_axil.rready
        |=> o_axil.rvalid && $stable(o_axil.rdata)) else $error("read answer dropped");
    AST_RD_UPPER: assert property (o_axil.rvalid |-> o_axil.rdata[31:8] == 24'h0)
        else $error("upper read bits set");
    AST_PD_STROBE: assert property (s_pd2 |-> !o_ale && !o_program_store_strobe)
        else $error("power-down strobes high");
    AST_IDLE_STROBE: assert property (s_idle2 |-> o_ale && o_program_store_strobe)
        else $error("idle strobes low");
    AST_PD_HALT: assert property (o_osc_stop |-> o_cpu_halt)
        else $error("cpu runs in power-down");
    AST_HALT_QUIET: assert property (o_cpu_halt [*2] |-> !o_irq_request)
        else $error("request while halted");
    AST_RAM_BLOCK: assert property (o_ram_write_block |-> !o_cpu_halt && !o_osc_stop)
        else $error("ram block outside reset wait");
    AST_IDLE_RST: assert property ($rose(o_ram_write_block)
        |-> !o_internal_reset [*8] ##[1:30] o_internal_reset) else $error("bad reset wait");
endmodule

bind irq_lp_ctrl irq_lp_checker u_chk (.i_core_clk, .i_rst_n, .i_axil, .o_axil, .o_irq_request,
    .o_cpu_halt, .o_osc_stop, .o_internal_reset, .o_ram_write_block, .o_ale,
    .o_program_store_strobe);

// *** test/cpu_core_model.sv ***
/*
 CPU sequencer model: vectors to an offered request after a set delay.
 Assumes the request stands until the source is served.
*/
`timescale 1ns/100ps
module cpu_core_model (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_irq_request,
    input  wire logic [2:0] i_irq_vector_id,
    input  wire logic [3:0] i_ack_delay,
    output logic            o_vector_ack,
    output logic      [2:0] o_vector_id,
    output logic            o_core_ale,
    output logic            o_core_pss
);
    logic [3:0] wait_q;
    logic [3:0] seq_q;
    assign o_core_ale = seq_q[1];
    assign o_core_pss = seq_q[2];
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wait_q       <= 4'h0;
            seq_q        <= 4'h0;
            o_vector_ack <= 1'b0;
            o_vector_id  <= 3'h0;
        end else begin
            seq_q        <= seq_q + 4'h1;
            o_vector_ack <= 1'b0;
            // Scrambled outside an acknowledge so a stale id never matches
            o_vector_id  <= ~o_vector_id;
            if (!i_irq_request) begin
                wait_q <= 4'h0;
            end else if (wait_q == i_ack_delay) begin
                o_vector_ack <= 1'b1;
                o_vector_id  <= i_irq_vector_id;
                wait_q       <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule

// *** test/tb.sv ***
/*
 Self-checking bench for irq_lp_ctrl with a CPU sequencer model.
 Assumes registers at byte addresses 0x00 to 0x0C.
*/
`timescale 1ns/100ps
module tb;
    logic                  clk, rst_n, ext0_n, ext1_n, t0, t1, t2, trig, ser, rst_pin, ext_mem;
    logic                  irq, halt, osc, irst, rblk, ale, pss, p0f, p2a, ack, core_ale, core_pss;
    logic [2:0]            vec, ack_id;
    logic [3:0]            dly;
    irq_lp_pkg::axil_req_t axil_req;
    irq_lp_pkg::axil_rsp_t axil_rsp;
    int                    err_count, n_tests, cyc;
    irq_lp_ctrl u_dut (.i_core_clk(clk), .i_rst_n(rst_n), .i_axil(axil_req), .o_axil(axil_rsp),
        .i_external_request_0_n(ext0_n), .i_external_request_1_n(ext1_n),
        .i_timer0_overflow(t0), .i_timer1_overflow(t1), .i_timer2_rollover(t2),
        .i_timer2_trigger_pin(trig), .i_serial_irq(ser), .i_reset_pin(rst_pin),
        .i_vector_ack(ack), .i_vector_id(ack_id), .i_ext_program_mem(ext_mem),
        .i_core_ale(core_ale), .i_core_program_store_strobe(core_pss), .o_irq_request(irq),
        .o_irq_vector_id(vec), .o_cpu_halt(halt), .o_osc_stop(osc), .o_internal_reset(irst),
        .o_ram_write_block(rblk), .o_ale(ale), .o_program_store_strobe(pss),
        .o_port0_float(p0f), .o_port2_addr_drive(p2a));
    cpu_core_model u_core (.i_clk(clk), .i_rst_n(rst_n), .i_irq_request(irq),
        .i_irq_vector_id(vec), .i_ack_delay(dly), .o_vector_ack(ack), .o_vector_id(ack_id),
        .o_core_ale(core_ale), .o_core_pss(core_pss));
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er = 2'h0);
        @(posedge clk);
        axil_req.awaddr <= a;
        axil_req.wdata <= {24'h0, d};
        axil_req.awvalid <= 1'b1;
        axil_req.wvalid <= 1'b1;
        // Late bready lets the slave show that it holds its answer
        do begin
            @(posedge clk);
            if (axil_rsp.awready) axil_req.awvalid <= 1'b0;
            if (axil_rsp.wready) axil_req.wvalid <= 1'b0;
            if (axil_rsp.bvalid) axil_req.bready <= 1'b1;
        end while (!(axil_rsp.bvalid && axil_req.bready));
        axil_req.bready <= 1'b0;
        check(32'(axil_rsp.bresp), 32'(er));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er = 2'h0);
        @(posedge clk);
        axil_req.araddr <= a;
        axil_req.arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (axil_rsp.arready) axil_req.arvalid <= 1'b0;
            if (axil_rsp.rvalid) axil_req.rready <= 1'b1;
        end while (!(axil_rsp.rvalid && axil_req.rready));
        axil_req.rready <= 1'b0;
        check(axil_rsp.rdata, ed);
        check(32'(axil_rsp.rresp), 32'(er));
    endtask
    task automatic await(ref logic s, input logic v);
        for (int i = 0; i < 60 && s !== v; i++) @(posedge clk);
        check(32'(s), 32'(v));
    endtask
    task automatic fire(input int k, input logic on);
        case (k)
            0: ext0_n <= !on;
            1: t0 <= on;
            2: ext1_n <= !on;
            3: t1 <= on;
            4: ser <= on;
            default: t2 <= on;
        endcase
    endtask
    task automatic t_regs();
        rd(8'h00, 32'h0);
        wr(8'h00, 8'hFF);
        rd(8'h00, 32'hBF);
        wr(8'h10, 8'h01, 2'h2);
        rd(8'h10, 32'h0, 2'h2);
        wr(8'h00, 8'h00);
    endtask
    task automatic t_sources();
        for (int k = 0; k < 6; k++) begin
            dly <= k[0] ? 4'h9 : 4'h0;
            wr(8'h00, 8'(1 << k));
            fire(k, 1'b1);
            @(posedge clk);
            if (k inside {1, 3, 5}) fire(k, 1'b0);
            repeat (36) @(posedge clk);
            check(32'(irq), 32'h0);
            wr(8'h00, 8'h80 | 8'(1 << k));
            await(irq, 1'b1);
            check(32'(vec), 32'(k));
            fire(k, 1'b0);
            repeat (16) @(posedge clk);
            if (k == 5) rd(8'h04, 32'h80);
            wr(8'h04, 8'h00);
            wr(8'h00, 8'h00);
            await(irq, 1'b0);
        end
    endtask
    task automatic t_ext_flag();
        trig <= 1'b0;
        repeat (8) @(posedge clk);
        trig <= 1'b1;
        rd(8'h04, 32'h0);
        wr(8'h04, 8'h08);
        trig <= 1'b0;
        repeat (8) @(posedge clk);
        trig <= 1'b1;
        rd(8'h04, 32'h48);
        wr(8'h00, 8'hA0);
        await(irq, 1'b1);
        check(32'(vec), 32'h5);
        wr(8'h04, 8'h08);
        wr(8'h00, 8'h00);
        await(irq, 1'b0);
    endtask
    task automatic t_idle();
        ext_mem <= 1'b1;
        wr(8'h00, 8'h81);
        wr(8'h08, 8'h01);
        repeat (2) @(posedge clk);
        check(32'({halt, ale, pss, p0f, p2a}), 32'h1F);
        rd(8'h08, 32'h1);
        fire(0, 1'b1);
        await(halt, 1'b0);
        fire(0, 1'b0);
        // Let the poll snapshot drop the old request, or idle is left at once
        repeat (24) @(posedge clk);
        wr(8'h00, 8'h85);
        wr(8'h08, 8'h01);
        repeat (2) @(posedge clk);
        rst_pin <= 1'b1;
        await(rblk, 1'b1);
        check(32'(halt), 32'h0000_0000);
        await(irst, 1'b1);
        rst_pin <= 1'b0;
        await(irst, 1'b0);
        rd(8'h00, 32'h0);
    endtask
    task automatic t_pdown();
        wr(8'h00, 8'h81);
        wr(8'h08, 8'h02);
        repeat (2) @(posedge clk);
        check(32'({osc, halt, ale, pss, p0f, p2a}), 32'h32);
        fire(0, 1'b1);
        repeat (40) @(posedge clk);
        check(32'({osc, halt}), 32'h3);
        fire(0, 1'b0);
        rst_pin <= 1'b1;
        await(irst, 1'b1);
        rst_pin <= 1'b0;
        await(irst, 1'b0);
        rd(8'h00, 32'h0);
        check(32'(osc), 32'h0);
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        cyc = 0;
        forever begin
            @(posedge clk);
            cyc++;
            // Run needs about a thousand cycles
            if (cyc == 20000) begin
                err_count++;
                print_verdict();
            end
        end
    end
    initial begin
        {rst_n, ext_mem, t0, t1, t2, ser, rst_pin} = '0;
        {ext0_n, ext1_n, trig} = 3'h7;
        dly = 4'h0;
        axil_req = '0;
        axil_req.wstrb = 4'hF;
        err_count = 0;
        n_tests = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        t_regs();
        t_sources();
        t_ext_flag();
        t_idle();
        t_pdown();
        print_verdict();
    end
endmodule
